// File: hw/bgpwm_gate_ctrl.sv
`timescale 1ns/100ps
`include "bgpwm_defines.svh"

module bgpwm_gate_ctrl #(
    parameter int PER_W = 16
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire bgpwm_pkg::bgpwm_addr_t addr,
    input  wire bgpwm_pkg::bgpwm_data_t wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output bgpwm_pkg::bgpwm_data_t     rdata,
    input  wire logic                  internal_osc_clock,
    input  wire logic                  sync_pin,
    input  wire logic                  loop_demand,
    input  wire logic                  peak_cmp_trip,
    input  wire logic                  ilim_cmp_trip,
    output logic                       gate_drive,
    output bgpwm_pkg::bgpwm_sel2_t     slope_comp_select,
    output bgpwm_pkg::bgpwm_sel2_t     current_limit_threshold
);
    import bgpwm_pkg::*;

    // ****************************************************************
    // Parameter check.
    // ****************************************************************
    if (PER_W < 10 || PER_W > 16) begin : g_bad_width
        $error("PER_W must lie between 10 and 16.");
    end

    // ****************************************************************
    // Register file.
    // ****************************************************************
    logic        boost_enable;
    logic        period_source_select;
    logic        sync_edge_invert;
    bgpwm_freq_t internal_freq_select;
    bgpwm_sel2_t min_on_time_select;
    bgpwm_sel2_t min_off_time_select;

    // Address decode for writes and reads.
    wire hit_ctrl = (addr == `BGPWM_ADDR_CTRL);
    wire hit_freq = (addr == `BGPWM_ADDR_FREQ);
    wire hit_cfg  = (addr == `BGPWM_ADDR_CFG);
    wire hit_stat = (addr == `BGPWM_ADDR_STATUS);
    wire wr_ctrl  = wr & hit_ctrl;
    wire wr_freq  = wr & hit_freq;
    wire wr_cfg   = wr & hit_cfg;

    logic [PER_W-1:0] last_per;
    logic             sync_level;

    // Read data selection; unmapped addresses read as zero.
    wire bgpwm_data_t rd_ctrl = {29'h0, sync_edge_invert, period_source_select, boost_enable};
    wire bgpwm_data_t rd_freq = {27'h0, internal_freq_select};
    wire bgpwm_data_t rd_cfg  = {24'h0, current_limit_threshold, slope_comp_select,
                                 min_off_time_select, min_on_time_select};
    wire [15:0]       per_ext = 16'(last_per);
    wire bgpwm_data_t rd_stat = {per_ext, 14'h0, sync_level, gate_drive};
    wire bgpwm_data_t next_rdata = hit_ctrl ? rd_ctrl :
                                   hit_freq ? rd_freq :
                                   hit_cfg  ? rd_cfg  :
                                   hit_stat ? rd_stat : 32'h0000_0000;

    // Control register writes; frequency resets to zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {sync_edge_invert, period_source_select, boost_enable} <= `BGPWM_CTRL_RST;
            internal_freq_select <= `BGPWM_FREQ_RST;
            {current_limit_threshold, slope_comp_select,
             min_off_time_select, min_on_time_select} <= `BGPWM_CFG_RST;
        end else begin
            if (wr_ctrl) begin
                boost_enable         <= wdata[`BGPWM_CTRL_EN_BIT];
                period_source_select <= wdata[`BGPWM_CTRL_SRC_BIT];
                sync_edge_invert     <= wdata[`BGPWM_CTRL_INV_BIT];
            end
            if (wr_freq) begin
                internal_freq_select <= wdata[`BGPWM_FREQ_MSB:0];
            end
            if (wr_cfg) begin
                min_on_time_select      <= wdata[`BGPWM_CFG_TON_LSB +: 2];
                min_off_time_select     <= wdata[`BGPWM_CFG_TOFF_LSB +: 2];
                slope_comp_select       <= wdata[`BGPWM_CFG_SLOPE_LSB +: 2];
                current_limit_threshold <= wdata[`BGPWM_CFG_ILIM_LSB +: 2];
            end
        end
    end

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? next_rdata : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Internal period generation from the 8 MHz clock.
    // ****************************************************************
    logic       osc_q;
    logic [5:0] div_cnt;
    wire        osc_rise = internal_osc_clock & ~osc_q;
    wire        freq_off = (internal_freq_select == 5'h00);
    wire [5:0]  div_end  = 6'(`BGPWM_DIV_BASE) - {1'b0, internal_freq_select};
    wire        div_wrap = osc_rise & (div_cnt >= div_end);
    wire        int_tick = div_wrap & ~freq_off;

    // Divider counts oscillator edges; a zero setting holds it cleared.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_q   <= 1'b0;
            div_cnt <= 6'h00;
        end else begin
            osc_q <= internal_osc_clock;
            if (freq_off) begin
                div_cnt <= 6'h00;
            end else if (osc_rise) begin
                div_cnt <= div_wrap ? 6'h00 : div_cnt + 6'h01;
            end
        end
    end

    // ****************************************************************
    // External sync path.
    // ****************************************************************
    logic sync_rise;
    logic sync_fall;

    bgpwm_sync_deb u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .sync_in (sync_pin),
        .level   (sync_level),
        .rise    (sync_rise),
        .fall    (sync_fall)
    );

    // Edge polarity and source selection.
    wire ext_tick    = sync_edge_invert ? sync_fall : sync_rise;
    wire period_tick = period_source_select ? ext_tick : int_tick;

    // ****************************************************************
    // Minimum on and off time tables, in clock cycles.
    // ****************************************************************
    wire [PER_W-1:0] ton_cyc =
        (min_on_time_select == 2'h0) ? PER_W'(`BGPWM_NS2CYC(`BGPWM_TON0_NS)) :
        (min_on_time_select == 2'h1) ? PER_W'(`BGPWM_NS2CYC(`BGPWM_TON1_NS)) :
        (min_on_time_select == 2'h2) ? PER_W'(`BGPWM_NS2CYC(`BGPWM_TON2_NS)) :
                                       PER_W'(`BGPWM_NS2CYC(`BGPWM_TON3_NS));
    wire [PER_W-1:0] toff_cyc =
        (min_off_time_select == 2'h0) ? PER_W'(`BGPWM_NS2CYC(`BGPWM_TOFF0_NS)) :
        (min_off_time_select == 2'h1) ? PER_W'(`BGPWM_NS2CYC(`BGPWM_TOFF1_NS)) :
        (min_off_time_select == 2'h2) ? PER_W'(`BGPWM_NS2CYC(`BGPWM_TOFF2_NS)) :
                                        PER_W'(`BGPWM_NS2CYC(`BGPWM_TOFF3_NS));

    // ****************************************************************
    // Gate state machine.
    // ****************************************************************
    bgpwm_state_t     state;
    bgpwm_state_t     next_state;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] on_cnt;
    logic [PER_W-1:0] off_cnt;

    // Maximum on length is the last period minus the minimum off-time.
    wire [PER_W-1:0] on_max  = (last_per > toff_cyc) ? last_per - toff_cyc : '0;
    wire [PER_W-1:0] on_next = on_cnt + PER_W'(1);
    wire             min_met = (on_next >= ton_cyc);
    wire             max_hit = (on_next >= on_max);
    wire             off_ok  = (off_cnt >= toff_cyc);
    wire             cmp_off = min_met & (peak_cmp_trip | ilim_cmp_trip);
    wire             start   = boost_enable & period_tick & loop_demand & off_ok;
    wire             stop    = ~boost_enable | period_tick | max_hit | cmp_off;

    // Next state of the gate.
    always_comb begin
        next_state = state;
        case (state)
            BGPWM_GATE_OFF: begin
                if (start) begin
                    next_state = BGPWM_GATE_ON;
                end
            end
            BGPWM_GATE_ON: begin
                if (stop) begin
                    next_state = BGPWM_GATE_OFF;
                end
            end
            default: begin
                next_state = BGPWM_GATE_OFF;
            end
        endcase
    end

    // State, gate output and the on, off and period counters.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state      <= BGPWM_GATE_OFF;
            gate_drive <= 1'b0;
            on_cnt     <= '0;
            off_cnt    <= '0;
            per_cnt    <= '0;
            last_per   <= '0;
        end else begin
            state      <= next_state;
            gate_drive <= (next_state == BGPWM_GATE_ON);
            on_cnt     <= (state == BGPWM_GATE_ON) ? on_next : '0;
            if (next_state == BGPWM_GATE_ON) begin
                off_cnt <= '0;
            end else if (~&off_cnt) begin
                off_cnt <= off_cnt + PER_W'(1);
            end
            if (period_tick) begin
                per_cnt  <= PER_W'(1);
                last_per <= per_cnt;
            end else if (~&per_cnt) begin
                per_cnt <= per_cnt + PER_W'(1);
            end
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_on_min_met;
        (state == BGPWM_GATE_ON) && min_met;
    endsequence

    a_peak_ends_on: assert property (
        s_on_min_met and (peak_cmp_trip && !ilim_cmp_trip) |=> !gate_drive)
        else $error("Peak trip did not end the on-phase.");

    a_slope_update: assert property (
        wr_cfg |=> slope_comp_select == $past(wdata[5:4]))
        else $error("Slope setting not taken from the write.");

    a_ilim_ends_on: assert property (
        s_on_min_met and ilim_cmp_trip |=> !gate_drive ##1 (state == BGPWM_GATE_OFF))
        else $error("Current limit did not switch the gate off.");

    a_source_select: assert property (
        !period_source_select && ext_tick && !int_tick |=> $stable(last_per))
        else $error("Sync edge used while internal source selected.");

    a_enable_gates: assert property (
        !boost_enable |=> !gate_drive)
        else $error("Gate high while the converter is disabled.");

    a_freq_divider: assert property (
        int_tick |=> div_cnt == 6'h00)
        else $error("Divider did not restart on the period tick.");

    a_freq_zero: assert property (
        !period_source_select && freq_off |=> !$rose(gate_drive))
        else $error("Gate started with internal frequency zero.");

    a_edge_polar: assert property (
        period_source_select && sync_edge_invert && sync_rise |-> !period_tick)
        else $error("Rising sync edge used with inverted polarity.");

    a_min_on_hold: assert property (
        gate_drive && !min_met && boost_enable && !period_tick && !max_hit |=> gate_drive)
        else $error("Gate ended before the minimum on-time.");

    a_no_demand: assert property (
        !gate_drive && period_tick && !loop_demand |=> !gate_drive)
        else $error("Pulse issued without loop demand.");

    a_min_off_hold: assert property (
        $rose(gate_drive) |-> $past(off_cnt) >= $past(toff_cyc))
        else $error("Gate restarted before the minimum off-time.");

    a_start_on_tick: assert property (
        $rose(gate_drive) |-> $past(period_tick) && $past(boost_enable))
        else $error("On-phase started away from a period tick.");

endmodule : bgpwm_gate_ctrl

// File: pkg/bgpwm_defines.svh
`ifndef BGPWM_DEFINES_SVH
`define BGPWM_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define BGPWM_ADDR_CTRL   8'h00
`define BGPWM_ADDR_FREQ   8'h04
`define BGPWM_ADDR_CFG    8'h08
`define BGPWM_ADDR_STATUS 8'h0C

// ****************************************************************
// Field positions.
// ****************************************************************
`define BGPWM_CTRL_EN_BIT   0
`define BGPWM_CTRL_SRC_BIT  1
`define BGPWM_CTRL_INV_BIT  2
`define BGPWM_FREQ_MSB      4
`define BGPWM_CFG_TON_LSB   0
`define BGPWM_CFG_TOFF_LSB  2
`define BGPWM_CFG_SLOPE_LSB 4
`define BGPWM_CFG_ILIM_LSB  6
`define BGPWM_STAT_GATE_BIT 0
`define BGPWM_STAT_SYNC_BIT 1
`define BGPWM_STAT_PER_LSB  16

// ****************************************************************
// Reset values.
// ****************************************************************
`define BGPWM_CTRL_RST 3'h0
`define BGPWM_FREQ_RST 5'h00
`define BGPWM_CFG_RST  8'h00

// ****************************************************************
// Timing: clock period, divider base and minimum on/off times.
// ****************************************************************
`define BGPWM_CLK_NS   10
`define BGPWM_DIV_BASE 38
`define BGPWM_NS2CYC(ns) (((ns) + `BGPWM_CLK_NS - 1) / `BGPWM_CLK_NS)
`define BGPWM_TON0_NS  100
`define BGPWM_TON1_NS  200
`define BGPWM_TON2_NS  300
`define BGPWM_TON3_NS  400
`define BGPWM_TOFF0_NS 50
`define BGPWM_TOFF1_NS 100
`define BGPWM_TOFF2_NS 200
`define BGPWM_TOFF3_NS 400

`endif

// File: pkg/bgpwm_pkg.sv
package bgpwm_pkg;

    // Gate phase of the switching period.
    typedef enum logic {
        BGPWM_GATE_OFF,
        BGPWM_GATE_ON
    } bgpwm_state_t;

    typedef logic [7:0]  bgpwm_addr_t;
    typedef logic [31:0] bgpwm_data_t;
    typedef logic [1:0]  bgpwm_sel2_t;
    typedef logic [4:0]  bgpwm_freq_t;

endpackage : bgpwm_pkg

// File: hw/bgpwm_sync_deb.sv
`timescale 1ns/100ps

module bgpwm_sync_deb (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic sync_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    import bgpwm_pkg::*;

    logic s1;
    logic s2;
    wire  stable = (s1 == s2);

    // Two consecutive equal samples are needed before the level follows.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else begin
            s1    <= sync_in;
            s2    <= s1;
            level <= stable ? s2 : level;
            rise  <= stable & s2 & ~level;
            fall  <= stable & ~s2 & level;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_debounce_stable: assert property (
        $changed(level) |-> ($past(sync_in, 2) == level) && ($past(sync_in, 3) == level))
        else $error("Sync level changed without two stable samples.");

endmodule : bgpwm_sync_deb

// File: testbench/bgpwm_far_side.sv
`timescale 1ns/100ps

// ****************************************************************
// Far side: switch current sense comparators and external sync source.
// ****************************************************************
module bgpwm_far_side (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        gate_drive,
    input  wire logic        sync_run,
    input  wire logic        sync_glitch,
    input  wire logic [15:0] sync_half,
    input  wire logic [15:0] peak_delay,
    input  wire logic [15:0] ilim_delay,
    output logic             sync_pin,
    output logic             peak_cmp_trip,
    output logic             ilim_cmp_trip
);
    logic [15:0] on_cnt;
    logic [15:0] phase;
    logic        wrap;
    logic        glitch;

    assign wrap   = (phase + 16'h0001 == sync_half);
    assign glitch = sync_glitch && (phase == 16'h0008 || phase == 16'h0009);

    // Current ramps while the switch is on; the sync line stands still unless running.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            on_cnt   <= 16'h0000;
            phase    <= 16'h0000;
            sync_pin <= 1'b0;
        end else begin
            on_cnt <= gate_drive ? on_cnt + 16'h0001 : 16'h0000;
            if (sync_run) begin
                phase <= wrap ? 16'h0000 : phase + 16'h0001;
                if (wrap || glitch) begin
                    sync_pin <= !sync_pin;
                end
            end
        end
    end

    // Both comparators see zero current once the switch is off.
    assign peak_cmp_trip = gate_drive && on_cnt >= peak_delay;
    assign ilim_cmp_trip = gate_drive && on_cnt >= ilim_delay;
endmodule : bgpwm_far_side

// File: testbench/boost_gate_pwm_controller_test.sv
`timescale 1ns/100ps
`include "bgpwm_defines.svh"

module boost_gate_pwm_controller_test;
    import bgpwm_pkg::*;
    logic        ref_clk, rst, wr, rd, internal_osc_clock, loop_demand;
    logic        sync_pin, peak_cmp_trip, ilim_cmp_trip, gate_drive, sync_run, sync_glitch;
    logic [15:0] sync_half, peak_delay, ilim_delay;
    bgpwm_addr_t addr;
    bgpwm_data_t wdata, rdata, d;
    bgpwm_sel2_t slope_comp_select, current_limit_threshold;
    logic [31:0] seed;
    int          mismatches, num_checks, cyc, osc_cnt, t_f, c, i;
    int          rises[$], wids[$], gaps[$], srise[$], sfall[$];
    int          off_tab[4] = '{5, 10, 20, 40};
    int          f_tab[3] = '{31, 1, 15};
    bit          g_q, s_q, f_ok;

    bgpwm_gate_ctrl #(.PER_W(16)) dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .internal_osc_clock(internal_osc_clock),
        .sync_pin(sync_pin), .loop_demand(loop_demand), .peak_cmp_trip(peak_cmp_trip),
        .ilim_cmp_trip(ilim_cmp_trip), .gate_drive(gate_drive),
        .slope_comp_select(slope_comp_select), .current_limit_threshold(current_limit_threshold));

    bgpwm_far_side far (.ref_clk(ref_clk), .rst(rst), .gate_drive(gate_drive),
        .sync_run(sync_run), .sync_glitch(sync_glitch), .sync_half(sync_half),
        .peak_delay(peak_delay), .ilim_delay(ilim_delay), .sync_pin(sync_pin),
        .peak_cmp_trip(peak_cmp_trip), .ilim_cmp_trip(ilim_cmp_trip));

    // ****************************************************************
    // Model: clock, oscillator, expected timing and helpers.
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = !ref_clk;
    end

    // Oscillator gives two rising edges every 25 cycles, about 8 MHz.
    always @(posedge ref_clk) begin
        osc_cnt <= (osc_cnt == 24) ? 0 : osc_cnt + 1;
        internal_osc_clock <= (osc_cnt < 6) || (osc_cnt >= 12 && osc_cnt < 18);
    end

    // Gate and sync edges are logged in cycles for the timing comparisons.
    always @(posedge ref_clk) begin
        cyc++;
        if (gate_drive === 1'b1 && !g_q) begin
            if (f_ok) gaps.push_back(cyc - t_f);
            rises.push_back(cyc);
        end
        if (gate_drive !== 1'b1 && g_q && rises.size() > 0) begin
            wids.push_back(cyc - rises[$]);
            t_f = cyc;
            f_ok = 1;
        end
        if (sync_pin === 1'b1 && !s_q) srise.push_back(cyc);
        if (sync_pin === 1'b0 && s_q) sfall.push_back(cyc);
        g_q = (gate_drive === 1'b1);
        s_q = (sync_pin === 1'b1);
    end

    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function int per_of(input int f);
        return (39 - f) * 25 / 2;
    endfunction : per_of

    function int per();
        return (rises.size() > 1) ? rises[$] - rises[$-1] : -1;
    endfunction : per

    function int lw();
        return (wids.size() > 0) ? wids[$] : -1;
    endfunction : lw

    function int align(input int sq[$]);
        int dl;
        if (rises.size() == 0 || sq.size() < 2) return -1;
        dl = rises[$] - sq[$];
        if (dl < 0) dl = rises[$] - sq[$-1];
        return dl;
    endfunction : align

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task wr_reg(input bgpwm_addr_t a, input bgpwm_data_t v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input bgpwm_addr_t a, output bgpwm_data_t v);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // Edges launched by the previous setting drain for three cycles before logging restarts.
    task run(input int n);
        repeat (3) @(negedge ref_clk);
        rises.delete();
        wids.delete();
        gaps.delete();
        srise.delete();
        sfall.delete();
        f_ok = 0;
        repeat (n) @(posedge ref_clk);
    endtask : run

    task tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // A hang ends the run as a mismatch.
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0; loop_demand = 1'b1;
        sync_run = 1'b0; sync_glitch = 1'b0; sync_half = 16'h0064;
        peak_delay = 16'h001E; ilim_delay = 16'h00C8; seed = 32'hD19FACDD;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd_reg(`BGPWM_ADDR_CTRL, d); check(d, 0);
        rd_reg(`BGPWM_ADDR_FREQ, d); check(d, 0);
        rd_reg(`BGPWM_ADDR_CFG, d); check(d, 0);
        rd_reg(8'h10, d); check(d, 0);
        rd_reg(`BGPWM_ADDR_STATUS, d); check(d, 0);
        check(gate_drive, 0);
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr_reg(`BGPWM_ADDR_CFG, {24'h0, seed[7:0]});
            rd_reg(`BGPWM_ADDR_CFG, d); check(d, {24'h0, seed[7:0]});
            check(slope_comp_select, seed[5:4]);
            check(current_limit_threshold, seed[7:6]);
        end
        // Internal periods, peak trip after 30 cycles of conduction.
        wr_reg(`BGPWM_ADDR_CFG, 0);
        wr_reg(`BGPWM_ADDR_CTRL, 1);
        for (i = 0; i < 3; i++) begin
            wr_reg(`BGPWM_ADDR_FREQ, f_tab[i]);
            run(4 * per_of(f_tab[i]) + 100);
            check(per(), per_of(f_tab[i]));
            check(lw() >= 30 && lw() <= 32, 1);
            rd_reg(`BGPWM_ADDR_STATUS, d); check(d[31:16], per_of(f_tab[i]));
        end
        // One comparator trips at once, peak then limit by turns; the pulse still lasts the minimum on-time.
        wr_reg(`BGPWM_ADDR_FREQ, 31);
        for (c = 0; c < 4; c++) begin
            peak_delay <= c[0] ? 16'h00C8 : 16'h0000;
            ilim_delay <= c[0] ? 16'h0000 : 16'h00C8;
            wr_reg(`BGPWM_ADDR_CFG, c);
            run(400); check(lw(), 10 * (c + 1));
        end
        peak_delay <= 16'h00C8; ilim_delay <= 16'h0028;
        wr_reg(`BGPWM_ADDR_CFG, 0);
        run(400); check(lw() >= 40 && lw() <= 42, 1);
        // No trip at all: duty is capped by the minimum off-time.
        ilim_delay <= 16'h00C8; // The limit sits well above any normal peak.
        for (c = 0; c < 4; c++) begin
            wr_reg(`BGPWM_ADDR_CFG, c << 2);
            run(500);
            check(lw() >= 99 - off_tab[c] && lw() <= 101 - off_tab[c], 1);
            check(gaps.size() > 0 && gaps[$] >= off_tab[c], 1);
        end
        loop_demand <= 1'b0;
        run(400); check(rises.size(), 0);
        loop_demand <= 1'b1;
        wr_reg(`BGPWM_ADDR_FREQ, 0);
        run(400); check(rises.size(), 0);
        wr_reg(`BGPWM_ADDR_FREQ, 31);
        wr_reg(`BGPWM_ADDR_CTRL, 0); // Amplifier gain lies outside this block.
        run(400); check(rises.size(), 0);
        sync_run <= 1'b1;
        wr_reg(`BGPWM_ADDR_CTRL, 2);
        run(600); check(rises.size(), 0);
        // External sync, rising then falling alignment, then a one-cycle glitch.
        peak_delay <= 16'h0014;
        wr_reg(`BGPWM_ADDR_CTRL, 3);
        run(1000); check(per(), 200);
        check(align(srise) >= 3 && align(srise) <= 5, 1);
        wr_reg(`BGPWM_ADDR_CTRL, 7);
        run(1000); check(per(), 200);
        check(align(sfall) >= 3 && align(sfall) <= 5, 1);
        sync_glitch <= 1'b1;
        run(1000); check(per(), 200);
        tally_and_finish();
    end
endmodule : boost_gate_pwm_controller_test
